// ==== design/acc_cfg.svh ====
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// Clock period in picoseconds (125 MHz).
`define ACC_CLK_PERIOD_PS 8000
// Trigger to ready-high delay: typical 1 us, longest 1.5 us, in ns.
`define ACC_TRIG_READY_TYP_NS 1000
`define ACC_TRIG_READY_MAX_NS 1500
// Internal reset completes at the typical figure; an LSB of one adds a little.
`define ACC_RESET_CYCLES ((`ACC_TRIG_READY_TYP_NS * 1000) / `ACC_CLK_PERIOD_PS)
`define ACC_RESET_MAX_CYCLES ((`ACC_TRIG_READY_MAX_NS * 1000) / `ACC_CLK_PERIOD_PS)
`define ACC_LSB_EXTRA_CYCLES 8
// Conversion time: typical 20 us, longest 30 us, in ns.
`define ACC_CONV_TYP_NS 20000
`define ACC_CONV_MAX_NS 30000
// Cycles per approximation step so that eight steps take the typical time.
`define ACC_STEP_CYCLES ((`ACC_CONV_TYP_NS * 1000) / `ACC_CLK_PERIOD_PS / 8)
`define ACC_CONV_MAX_CYCLES ((`ACC_CONV_MAX_NS * 1000) / `ACC_CLK_PERIOD_PS)
// Trigger pulse widths: tested 500 ns, typically works down to 300 ns.
`define ACC_TRIG_TESTED_NS 500
`define ACC_TRIG_MIN_NS 300
// Offset binary midscale, the first trial code.
`define ACC_MIDSCALE 8'h80

`endif

// ==== design/acc_pkg.sv ====
package acc_pkg;
   // Sequencer states.
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_RESET = 2'b01,
      ACC_WAIT = 2'b10,
      ACC_CONVERT = 2'b11
   } acc_state_t;

   // Result bus as seen on the three-state pins.
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] oe;
   } acc_bus_t;
endpackage

// ==== design/acc_sar.sv ====
`timescale 1ns/1ps
`include "acc_cfg.svh"

// Successive approximation register: one trial bit per step, MSB first.
module acc_sar #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Control.
   input wire logic clear_in,
   input wire logic start_in,
   input wire logic step_in,
   input wire logic comp_in,
   // Result.
   output logic [WIDTH-1:0] result_out,
   output logic done_out
);
   logic [WIDTH-1:0] result_reg;
   logic [WIDTH-1:0] result_next;
   logic [WIDTH-1:0] trial_reg;
   logic [WIDTH-1:0] trial_next;
   logic done_reg;
   logic done_next;
   wire logic [WIDTH-1:0] kept_w = comp_in ? result_reg : (result_reg & ~trial_reg);
   wire logic [WIDTH-1:0] trial_shift_w = trial_reg >> 1;
   wire logic last_w = trial_reg[0];

   // Each decision keeps or drops the trial bit and sets the next lower one.
   always_comb begin
      result_next = result_reg;
      trial_next = trial_reg;
      done_next = done_reg;
      if (clear_in) begin
         result_next = '0;
         trial_next = '0;
         done_next = 1'b0;
      end else if (start_in) begin
         result_next = {1'b1, {(WIDTH-1){1'b0}}};
         trial_next = {1'b1, {(WIDTH-1){1'b0}}};
         done_next = 1'b0;
      end else if (step_in && trial_reg != '0) begin
         result_next = kept_w | trial_shift_w;
         trial_next = trial_shift_w;
         done_next = last_w;
      end
   end

   // State registers.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         result_reg <= '0;
         trial_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         result_reg <= result_next;
         trial_reg <= trial_next;
         done_reg <= done_next;
      end
   end

   assign result_out = result_reg;
   assign done_out = done_reg;
endmodule // acc_sar

// ==== design/acc_ctrl.sv ====
`timescale 1ns/1ps
`include "acc_cfg.svh"

// How it works
// - Trigger rising edge resets sequencer, clears result, drives ready high.
// - Approximation starts at trigger fall, or at ready rise if trigger fell during reset; ready goes low when finished.
// - Host keeps enable high during conversion; else partial results appear.
// - Result pins driven only while enable is low, otherwise released.
// - Ready goes high about 1 us after trigger, at most 1.5 us.
// - Ready delay is slightly longer when previous LSB was one.
// - Works with 500 ns trigger pulse, typically down to 300 ns.
// - Result is offset binary: midscale input gives 8'h80.
module acc_ctrl #(
   parameter int WIDTH = 8,
   parameter int RESET_CYCLES = `ACC_RESET_CYCLES,
   parameter int STEP_CYCLES = `ACC_STEP_CYCLES
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Host control pins.
   input wire logic convert_trigger_in,
   input wire logic result_output_enable_n_in,
   // Comparator decision: high keeps the trial bit.
   input wire logic comparator_in,
   // Status and result pins.
   output logic result_ready_n_out,
   output logic [WIDTH-1:0] data_out,
   output logic [WIDTH-1:0] data_oe_out
);
   localparam int CW = 16;
   // Longest trigger-to-ready delay in clock cycles.
   localparam int READY_MAX = `ACC_RESET_MAX_CYCLES;

   acc_pkg::acc_state_t state_reg;
   acc_pkg::acc_state_t state_next;
   logic trig_d_reg;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic ready_n_reg;
   logic ready_n_next;
   acc_pkg::acc_bus_t bus_reg;
   acc_pkg::acc_bus_t bus_next;
   logic [WIDTH-1:0] result_w;
   logic done_w;

   // Edge detection on the trigger, taken as synchronous.
   wire logic trig_rise_w = convert_trigger_in && !trig_d_reg;
   wire logic trig_fall_w = !convert_trigger_in && trig_d_reg;
   wire logic cnt_zero_w = (cnt_reg == '0);
   wire logic in_reset_w = (state_reg == acc_pkg::ACC_RESET);
   wire logic in_conv_w = (state_reg == acc_pkg::ACC_CONVERT);
   // Start on a low trigger in the wait state, not only on its edge, so a short
   // trigger that fell during the internal reset still starts the approximation.
   wire logic start_w = (state_reg == acc_pkg::ACC_WAIT) && !convert_trigger_in;
   wire logic step_w = in_conv_w && cnt_zero_w;
   // A stored LSB of one stretches the internal reset slightly.
   wire logic [CW-1:0] reset_load_w = result_w[0] ?
      CW'(RESET_CYCLES + `ACC_LSB_EXTRA_CYCLES - 1) : CW'(RESET_CYCLES - 1);

   // The approximation register itself.
   acc_sar #(
      .WIDTH(WIDTH)
   ) u_sar (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .clear_in(trig_rise_w),
      .start_in(start_w),
      .step_in(step_w),
      .comp_in(comparator_in),
      .result_out(result_w),
      .done_out(done_w)
   );

   // Sequencer. A new rising edge restarts it from any state, so a trigger
   // during conversion aborts the running approximation.
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_zero_w ? cnt_reg : cnt_reg - CW'(1);
      ready_n_next = ready_n_reg;
      if (trig_rise_w) begin
         state_next = acc_pkg::ACC_RESET;
         cnt_next = reset_load_w;
      end else begin
         case (state_reg)
            acc_pkg::ACC_RESET: begin
               if (cnt_zero_w) begin
                  ready_n_next = 1'b1;
                  state_next = acc_pkg::ACC_WAIT;
               end
            end
            acc_pkg::ACC_WAIT: begin
               // A short trigger may fall before reset completes; it is
               // held here and starts the moment ready has gone high.
               if (!convert_trigger_in) begin
                  state_next = acc_pkg::ACC_CONVERT;
                  cnt_next = CW'(STEP_CYCLES - 1);
               end
            end
            acc_pkg::ACC_CONVERT: begin
               if (done_w) begin
                  ready_n_next = 1'b0;
                  state_next = acc_pkg::ACC_IDLE;
               end else if (cnt_zero_w) begin
                  cnt_next = CW'(STEP_CYCLES - 1);
               end
            end
            default: begin
               state_next = acc_pkg::ACC_IDLE;
            end
         endcase
      end
   end

   // Output pins: enable releases or drives them; partial results show if
   // the host enables during conversion.
   always_comb begin
      bus_next.data = result_w;
      bus_next.oe = result_output_enable_n_in ? '0 : '1;
   end

   // State registers.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= acc_pkg::ACC_IDLE;
         trig_d_reg <= 1'b0;
         cnt_reg <= '0;
         ready_n_reg <= 1'b0;
         bus_reg <= '0;
      end else begin
         state_reg <= state_next;
         trig_d_reg <= convert_trigger_in;
         cnt_reg <= cnt_next;
         ready_n_reg <= ready_n_next;
         bus_reg <= bus_next;
      end
   end

   assign result_ready_n_out = ready_n_reg;
   assign data_out = bus_reg.data;
   assign data_oe_out = bus_reg.oe;

   // Cycles spent converting, so the longest conversion time is checked with a
   // counter rather than with a delay range far beyond what the tools unroll.
   logic [CW-1:0] conv_age_reg;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         conv_age_reg <= '0;
      end else if (in_conv_w) begin
         conv_age_reg <= conv_age_reg + CW'(1);
      end else begin
         conv_age_reg <= '0;
      end
   end

   // Ready rises within the longest delay after the trigger edge.
   AST_READY_DELAY: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      trig_rise_w |-> ##[1:READY_MAX] ready_n_reg)
      else $error("ready not high within reset delay");

   // Ready stays low for the first 8 cycles after a trigger edge that finds it low.
   AST_READY_NOT_EARLY: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (trig_rise_w && !ready_n_reg) |=> !ready_n_reg [*8])
      else $error("ready rose too early");

   // Result is cleared the cycle after a trigger rise.
   AST_CLEAR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      trig_rise_w |=> result_w == '0)
      else $error("result not cleared");

   // Conversion starts with the midscale trial.
   AST_START_MID: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      start_w |=> result_w == `ACC_MIDSCALE)
      else $error("first trial is not midscale");

   // Enable low drives the pins on the next edge; high releases them.
   AST_OE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      1'b1 |=> (data_oe_out == ($past(result_output_enable_n_in) ? '0 : '1)))
      else $error("pin drive does not follow enable");

   // Ready falls within the longest conversion time of the start.
   AST_CONV_DONE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      conv_age_reg <= CW'(`ACC_CONV_MAX_CYCLES))
      else $error("conversion did not finish in time");

   // Ready falls only out of conversion.
   AST_READY_FALL: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      $fell(ready_n_reg) |-> $past(in_conv_w))
      else $error("ready fell outside conversion");

   // A step moves the trial bit down by one position.
   AST_STEP: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (step_w && !trig_rise_w && !done_w && u_sar.trial_reg[0] == 1'b0 &&
       u_sar.trial_reg != '0) |=> u_sar.trial_reg == $past(u_sar.trial_reg) >> 1)
      else $error("trial bit did not advance");
endmodule // acc_ctrl

// ==== dv/acc_host_model.sv ====
`timescale 1ns/1ps

// Host side: a decoded write starts a conversion, a decoded read enables the result.
module acc_host_model (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Bus cycles and analog level from the bench.
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] level_in,
   // Converter pins.
   input wire logic ready_n_in,
   input wire logic [7:0] pins_in,
   output logic trigger_out,
   output logic enable_n_out,
   output logic comp_out
);
   logic ready_n_reg;

   // A bus strobe is too short for the converter, so it sets a stretcher that the
   // ready rise clears; the pulse then lasts the whole internal reset.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         trigger_out <= 1'b0;
         ready_n_reg <= 1'b0;
      end else begin
         ready_n_reg <= ready_n_in;
         if (wr_in) begin
            trigger_out <= 1'b1;
         end else if (ready_n_in && !ready_n_reg) begin
            trigger_out <= 1'b0;
         end
      end
   end

   // Read decode and an ideal comparator on the offset binary scale.
   assign enable_n_out = ~rd_in;
   assign comp_out = (pins_in <= level_in);
endmodule // acc_host_model

// ==== dv/adc_conversion_control_read_port_tb_top.sv ====
`timescale 1ns/1ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
   $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

module adc_conversion_control_read_port_tb_top;
   localparam int RST = 125;
   // Longest conversion time and sample-hold acquisition time, in cycles.
   localparam int CONV_WAIT = 3750;
   localparam int ACQ_WAIT = 1250;
   logic clk, arst_n, wr, rd, trig, en_n, comp, ready_n;
   logic [7:0] level, data, oe, bus;
   int fails = 0;
   int checked = 0;
   int cyc = 0;

   acc_ctrl #(.RESET_CYCLES(RST), .STEP_CYCLES(4)) dut (.clk_in(clk), .arst_n_in(arst_n),
      .convert_trigger_in(trig), .result_output_enable_n_in(en_n), .comparator_in(comp),
      .result_ready_n_out(ready_n), .data_out(data), .data_oe_out(oe));

   acc_host_model host (.clk_in(clk), .arst_n_in(arst_n), .wr_in(wr), .rd_in(rd),
      .level_in(level), .ready_n_in(ready_n), .pins_in(data), .trigger_out(trig),
      .enable_n_out(en_n), .comp_out(comp));

   // Released pins float; a moving pattern keeps a stale value from passing.
   assign bus = (data & oe) | (~oe & cyc[7:0]);

   always #4 clk = ~clk;

   // Cut a hang short at about twice the roughly 9400 cycles the run needs.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end

   task automatic results();
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wait_ready(input logic lvl, output int n);
      n = 0;
      while (ready_n !== lvl && n < 400) begin
         @(negedge clk);
         n++;
      end
   endtask

   // One conversion by write, polled ready and read; optional peek while converting.
   task automatic convert(input logic [7:0] code, input int dly, input logic peek);
      int n;
      level = code;
      @(negedge clk) wr = 1'b1;
      @(negedge clk) wr = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(data, 8'h00)
      wait_ready(1'b1, n);
      `CHK(n + 3, dly)
      `CHK(oe, 8'h00)
      if (peek) begin
         repeat (10) @(negedge clk);
         rd = 1'b1;
         @(negedge clk);
         `CHK(oe, 8'hFF)
         `CHK(data[0], 1'b0)
         `CHK(ready_n, 1'b1)
         rd = 1'b0;
      end
      wait_ready(1'b0, n);
      `CHK(ready_n, 1'b0)
      rd = 1'b1;
      @(negedge clk);
      `CHK(oe, 8'hFF)
      `CHK(bus, code)
      rd = 1'b0;
      @(negedge clk);
      `CHK(oe, 8'h00)
      `CHK(ready_n, 1'b0)
      // Give a front-end sample-hold time to acquire before the next trigger.
      repeat (ACQ_WAIT) @(negedge clk);
   endtask

   // One conversion with a fixed wait instead of watching ready.
   task automatic fixed_wait(input logic [7:0] code);
      level = code;
      @(negedge clk) wr = 1'b1;
      @(negedge clk) wr = 1'b0;
      repeat (CONV_WAIT) @(negedge clk);
      rd = 1'b1;
      @(negedge clk);
      `CHK(bus, code)
      rd = 1'b0;
      @(negedge clk);
   endtask

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      level = 8'h00;
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      // Midscale first, then a stored LSB of one lengthens the next reset.
      convert(8'h80, RST + 1, 1'b0);
      convert(8'hA5, RST + 1, 1'b0);
      convert(8'hFF, RST + 9, 1'b1);
      convert(8'h00, RST + 9, 1'b0);
      fixed_wait(8'h3C);
      results();
   end
endmodule // adc_conversion_control_read_port_tb_top
